// ### rtl/usc_uart.sv
// Contract
// - mode bit 0 frames eight data bits, 1 frames nine; baud divider variable.
// - bit 6 reads as 1, writes to it are ignored.
// - 8-bit mode with multiproc enable: receive flag only if stop bit high.
// - 9-bit mode with multiproc enable: receive flag only if ninth bit high.
// - receiver runs only while receiver enable is 1.
// - 9-bit mode sends the tx ninth bit field as ninth data bit.
// - tx ninth bit unused in 8-bit mode; only software changes it.
// - 8-bit mode loads rx ninth bit with received stop bit.
// - 9-bit mode loads rx ninth bit with the ninth data bit.
// - tx done after eighth bit (8-bit) or at stop start (9-bit).
// - interrupt requested while enabled and either done flag is set.
// - receive flag sets when the stop bit is sampled, if accepted and the buffer has room.
//
// usc_uart: serial port control register with transmitter and receiver
// assumes: register port on ref_clk; rx pin asynchronous; divider sets bit time
`timescale 1ns/100ps
`default_nettype none
module usc_uart
	import usc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd,
	output logic [7:0]       sfr_rdata,
	input  wire logic [15:0] baud_div,
	input  wire logic        int_enable,
	input  wire logic        tx_start,
	input  wire logic [7:0]  tx_data,
	output logic             tx_busy,
	output logic             txd,
	input  wire logic        rxd,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	output logic [7:0]       rx_data,
	output logic             int_req
);
	logic               frame_mode_select_q;
	logic               multiproc_enable_q;
	logic               receiver_enable_q;
	logic               tx_ninth_bit_q;
	logic               rx_ninth_bit_q;
	logic               tx_done_flag_q;
	logic               rx_done_flag_q;
	logic               reg_wr;
	logic [7:0]         reg_val;
	logic [3:0]         nbits;
	// transmitter
	usc_link_state_type tx_st_q;
	logic [15:0]        tx_cnt_q;
	logic [3:0]         tx_idx_q;
	logic [8:0]         tx_sh_q;
	logic               tx_tick;
	logic               tx_done_set;
	// receiver
	logic               rx_s1_q;
	logic               rx_s2_q;
	usc_link_state_type rx_st_q;
	logic [15:0]        rx_cnt_q;
	logic [3:0]         rx_idx_q;
	logic [8:0]         rx_sh_q;
	logic               rx_tick;
	logic               rx_stop_now;
	logic               rx_accept;
	logic               rx_push;
	logic               buf_ready;
	usc_char_type       rx_char;
	usc_char_type       buf_out;
	logic               buf_valid;

	assign reg_wr = sfr_wr && (sfr_addr == SCON_ADDR);
	assign nbits  = frame_mode_select_q ? DATA_BITS_9 : DATA_BITS_8;
	assign reg_val = UNUSED_READ | {frame_mode_select_q, 1'b0, multiproc_enable_q,
		receiver_enable_q, tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q,
		rx_done_flag_q};

	// control bits: software only; bit 6 not stored
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			frame_mode_select_q <= SCON_RESET[BIT_MODE];
			multiproc_enable_q  <= SCON_RESET[BIT_MCE];
			receiver_enable_q   <= SCON_RESET[BIT_REN];
			tx_ninth_bit_q      <= SCON_RESET[BIT_TB8];
		end
		else if (reg_wr)
		begin
			frame_mode_select_q <= sfr_wdata[BIT_MODE];
			multiproc_enable_q  <= sfr_wdata[BIT_MCE];
			receiver_enable_q   <= sfr_wdata[BIT_REN];
			tx_ninth_bit_q      <= sfr_wdata[BIT_TB8];
		end
	end
	// done flags: hardware set wins over a software write in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tx_done_flag_q <= SCON_RESET[BIT_TI];
			rx_done_flag_q <= SCON_RESET[BIT_RI];
		end
		else
		begin
			if (tx_done_set)
				tx_done_flag_q <= 1'b1;
			else if (reg_wr)
				tx_done_flag_q <= sfr_wdata[BIT_TI];
			if (rx_push)
				rx_done_flag_q <= 1'b1;
			else if (reg_wr)
				rx_done_flag_q <= sfr_wdata[BIT_RI];
		end
	end
	// rx ninth bit: stop level in 8-bit mode, ninth data bit in 9-bit mode
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			rx_ninth_bit_q <= SCON_RESET[BIT_RB8];
		else if (rx_push)
			rx_ninth_bit_q <= rx_char.ninth;
		else if (reg_wr)
			rx_ninth_bit_q <= sfr_wdata[BIT_RB8];
	end
	// read data and interrupt, both registered
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sfr_rdata <= 8'h00;
			int_req   <= 1'b0;
		end
		else
		begin
			sfr_rdata <= (sfr_rd && sfr_addr == SCON_ADDR) ? reg_val : 8'h00;
			int_req   <= int_enable && (tx_done_flag_q || rx_done_flag_q);
		end
	end
	assign tx_tick = (tx_cnt_q == 16'h0000);
	// done fires as the last data bit ends (8-bit) or stop begins (9-bit)
	assign tx_done_set = tx_tick && (tx_st_q == LINK_DATA) && (tx_idx_q == nbits - 4'h1);
	// transmitter: start low, data lsb first, stop high
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tx_st_q  <= LINK_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_idx_q <= 4'h0;
			tx_sh_q  <= 9'h000;
			txd      <= 1'b1;
			tx_busy  <= 1'b0;
		end
		else
		begin
			tx_cnt_q <= tx_tick ? baud_div : tx_cnt_q - 16'h0001;
			unique case (tx_st_q)
				LINK_IDLE:
				begin
					txd     <= 1'b1;
					tx_busy <= tx_start;
					if (tx_start)
					begin
						tx_sh_q  <= {tx_ninth_bit_q, tx_data};
						tx_cnt_q <= baud_div;
						txd      <= 1'b0;
						tx_st_q  <= LINK_START;
					end
				end
				LINK_START:
					if (tx_tick)
					begin
						txd      <= tx_sh_q[0];
						tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
						tx_idx_q <= 4'h0;
						tx_st_q  <= LINK_DATA;
					end
				LINK_DATA:
					if (tx_tick)
					begin
						tx_idx_q <= tx_idx_q + 4'h1;
						txd      <= tx_sh_q[0];
						tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
						if (tx_idx_q == nbits - 4'h1)
						begin
							txd     <= 1'b1;
							tx_st_q <= LINK_STOP;
						end
					end
				LINK_STOP:
					if (tx_tick)
					begin
						tx_busy <= 1'b0;
						tx_st_q <= LINK_IDLE;
					end
			endcase
		end
	end

	// rx pin synchroniser
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end
		else
		begin
			rx_s1_q <= rxd;
			rx_s2_q <= rx_s1_q;
		end
	end

	assign rx_tick     = (rx_cnt_q == 16'h0000);
	assign rx_stop_now = rx_tick && (rx_st_q == LINK_STOP);
	// stop level lands as ninth in 8-bit mode
	assign rx_char = {frame_mode_select_q ? rx_sh_q[8] : rx_s2_q, rx_sh_q[7:0]};
	// with multiproc enable only, 8-bit: valid stop checked; 9-bit: address filter on ninth bit
	assign rx_accept = !multiproc_enable_q || rx_char.ninth;
	// a full buffer drops the char rather than stall the line
	assign rx_push   = rx_stop_now && rx_accept && buf_ready;

	// receiver: samples mid-bit; enable low aborts and holds idle
	always_ff @(posedge ref_clk)
	begin
		if (rst || !receiver_enable_q)
		begin
			rx_st_q  <= LINK_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_idx_q <= 4'h0;
			rx_sh_q  <= 9'h000;
		end
		else
		begin
			rx_cnt_q <= rx_tick ? baud_div : rx_cnt_q - 16'h0001;
			unique case (rx_st_q)
				LINK_IDLE:
					if (!rx_s2_q)
					begin
						rx_cnt_q <= {1'b0, baud_div[15:1]};
						rx_st_q  <= LINK_START;
					end
				LINK_START:
					if (rx_tick)
					begin
						rx_idx_q <= 4'h0;
						rx_st_q  <= rx_s2_q ? LINK_IDLE : LINK_DATA;
					end
				LINK_DATA:
					if (rx_tick)
					begin
						rx_sh_q[rx_idx_q] <= rx_s2_q;
						rx_idx_q          <= rx_idx_q + 4'h1;
						if (rx_idx_q == nbits - 4'h1)
							rx_st_q <= LINK_STOP;
					end
				LINK_STOP:
					if (rx_tick)
						rx_st_q <= LINK_IDLE;
			endcase
		end
	end

	usc_buf2 u_buf
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (rx_push),
		.in_ready  (buf_ready),
		.in_data   (rx_char),
		.out_valid (buf_valid),
		.out_ready (rx_ready && !rx_valid),
		.out_data  (buf_out)
	);

	// registered output stage for received bytes
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
		end
		else if (rx_valid)
			rx_valid <= 1'b0;
		else if (buf_valid && rx_ready)
		begin
			rx_valid <= 1'b1;
			rx_data  <= buf_out.data;
		end
	end
endmodule
`default_nettype wire

// ### rtl/usc_pkg.sv
// usc_pkg: constants and types for the serial control/status block
// assumes: one system clock, byte-wide special function register port
package usc_pkg;
	localparam logic [7:0] SCON_ADDR      = 8'h98;
	localparam int         BIT_MODE       = 7;
	localparam int         BIT_ONE        = 6;
	localparam int         BIT_MCE        = 5;
	localparam int         BIT_REN        = 4;
	localparam int         BIT_TB8        = 3;
	localparam int         BIT_RB8        = 2;
	localparam int         BIT_TI         = 1;
	localparam int         BIT_RI         = 0;
	localparam logic [7:0] SCON_RESET     = 8'h40;
	localparam logic [7:0] UNUSED_READ    = 8'h40;
	localparam logic [3:0] DATA_BITS_8    = 4'h8;
	localparam logic [3:0] DATA_BITS_9    = 4'h9;
	localparam logic [15:0] BAUD_DIV_RESET = 16'h00D9;

	typedef enum logic [1:0]
	{
		LINK_IDLE  = 2'b00,
		LINK_START = 2'b01,
		LINK_DATA  = 2'b10,
		LINK_STOP  = 2'b11
	} usc_link_state_type;

	// one character: low eight bits plus the ninth bit
	typedef struct packed
	{
		logic       ninth;
		logic [7:0] data;
	} usc_char_type;
endpackage

// ### rtl/usc_buf2.sv
// usc_buf2: two-entry valid/ready buffer for received characters
// assumes: source and sink on the same clock
`timescale 1ns/100ps
`default_nettype none
module usc_buf2
	import usc_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire usc_char_type in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output usc_char_type      out_data
);
	usc_char_type mem_q [2];
	logic         wr_q;
	logic         rd_q;
	logic [1:0]   cnt_q;
	logic         push;
	logic         pop;

	assign push      = in_valid && (cnt_q != 2'h2);
	assign pop       = out_valid && out_ready;
	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rd_q];

	// storage and pointers; full buffer refuses, the source must hold
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				mem_q[wr_q] <= in_data;
				wr_q        <= ~wr_q;
			end
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// ### verification/usc_uart_chk.sv
// usc_uart_chk: port assertions for the serial control block
// assumes: bench holds sfr_rd and int_enable low in reset
`timescale 1ns/100ps
`default_nettype none
module usc_uart_chk
	import usc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic [15:0] baud_div,
	input wire logic        int_enable,
	input wire logic        tx_start,
	input wire logic        tx_busy,
	input wire logic        txd,
	input wire logic        rx_valid,
	input wire logic        int_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// line rests at the stop level between frames
	a_txd_idle_high: assert property (!tx_busy |-> txd)
		else $error("txd low while idle");
	a_start_bit_low: assert property (tx_start && !tx_busy |=> !txd && tx_busy)
		else $error("no start bit");
	// start bit lasts one bit time (four clocks at divider 3)
	a_start_bit_len: assert property ($rose(tx_busy) && baud_div == 16'h0003 |-> (!txd)[*4])
		else $error("start bit length");
	a_stop_bit_high: assert property ($fell(tx_busy) |-> $past(txd))
		else $error("stop bit low");
	a_busy_needs_start: assert property (!tx_busy && !tx_start |=> !tx_busy)
		else $error("busy without start");
	a_bit6_reads_one: assert property (sfr_rd && sfr_addr == SCON_ADDR |=> sfr_rdata[BIT_ONE])
		else $error("bit6 read zero");
	a_rdata_quiet: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
		else $error("read data without read");
	a_int_masked: assert property (!int_enable |=> !int_req)
		else $error("int while disabled");
	c_tx: cover property (tx_start && !tx_busy);
	c_rx: cover property (rx_valid);
	c_int: cover property ($rose(int_req));
endmodule
bind usc_uart usc_uart_chk u_usc_uart_chk (.ref_clk, .rst, .sfr_addr, .sfr_rd, .sfr_rdata,
	.baud_div, .int_enable, .tx_start, .tx_busy, .txd, .rx_valid, .int_req);
`default_nettype wire

// ### verification/usc_remote.sv
// usc_remote: far transceiver, sends frames on rxd, samples txd
// assumes: divider fixed while frames are in flight
`timescale 1ns/100ps
`default_nettype none
module usc_remote
	import usc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic [15:0] baud_div,
	input  wire logic        txd,
	output logic             rxd,
	output logic [9:0]       cap,
	output logic [7:0]       cap_cnt
);
	// idle mark level until a frame is sent
	initial
		rxd = 1'b1;
	// start, data lsb first, ninth bit if asked, stop of given level
	task automatic send(input usc_char_type c, input logic nine, input logic stp, input int gap);
		logic [10:0] f;
		int          n;
		f = nine ? {stp, c.ninth, c.data, 1'b0} : {1'b1, stp, c.data, 1'b0};
		n = nine ? 11 : 10;
		repeat (gap + 1) @(posedge ref_clk);
		for (int k = 0; k < n; k++)
		begin
			rxd <= f[k];
			repeat (baud_div + 1) @(posedge ref_clk);
		end
		rxd <= 1'b1;
	endtask
	// mid-bit sampling on the falling edge, clear of the txd update
	initial
	begin
		cap = 10'h000;
		cap_cnt = 8'h00;
		forever
		begin
			@(negedge txd);
			repeat ((baud_div + 1) / 2) @(negedge ref_clk);
			for (int k = 0; k < 10; k++)
			begin
				repeat (baud_div + 1) @(negedge ref_clk);
				cap[k] = txd;
			end
			cap_cnt = cap_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ### verification/tb.sv
// tb: drives registers, transmit and receive through the remote model
// assumes: divider 3, so one bit lasts four clocks
`timescale 1ns/100ps
`default_nettype none
module tb
	import usc_pkg::*;
;
	logic         ref_clk, rst, sfr_wr, sfr_rd, int_enable, tx_start, tx_busy;
	logic         txd, rxd, rx_valid, rx_ready, int_req;
	logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata, tx_data, rx_data, r, got, c0;
	logic [15:0]  baud_div;
	logic [9:0]   cap;
	logic [7:0]   cap_cnt;
	logic         m, b, mce, ren, a, seen;
	usc_char_type c;
	int           error_cnt, samples_checked, i, n, k;
	usc_uart u_usc_uart (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
		.baud_div, .int_enable, .tx_start, .tx_data, .tx_busy, .txd, .rxd, .rx_valid,
		.rx_ready, .rx_data, .int_req);
	usc_remote u_usc_remote (.ref_clk, .baud_div, .txd, .rxd, .cap, .cap_cnt);
	// free-running 25 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever
			#20 ref_clk = ~ref_clk;
	end
	task automatic end_of_test;
		if (error_cnt == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// a stuck wait ends the run at once
	task automatic tmo(input logic ok);
		if (!ok)
		begin
			$display("MISMATCH wait exp done got stuck");
			error_cnt++;
			end_of_test;
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] v);
		@(negedge ref_clk);
		sfr_addr = ad;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
		sfr_addr = SCON_ADDR;
	endtask
	task automatic rd(output logic [7:0] v);
		@(negedge ref_clk);
		sfr_rd = 1'b1;
		@(negedge ref_clk);
		sfr_rd = 1'b0;
		v = sfr_rdata;
	endtask
	// expected register image, bit6 always set
	function automatic logic [7:0] ctl(input logic md, input logic mc, input logic rn,
		input logic t8, input logic r8, input logic ti, input logic ri);
		return {md, 1'b1, mc, rn, t8, r8, ti, ri};
	endfunction
	initial
	begin
		{rst, sfr_wr, sfr_rd, int_enable, tx_start, rx_ready} = 6'b100001;
		{sfr_wdata, tx_data} = 16'h0000;
		sfr_addr = SCON_ADDR;
		baud_div = 16'h0003;
		error_cnt = 0;
		samples_checked = 0;
		void'($urandom(70747));
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		rd(r);
		chk("ctrl_reset", SCON_RESET, r);
		wr(SCON_ADDR, 8'h08);
		wr(8'h99, 8'hFF);
		rd(r);
		chk("ctrl_bit6", 8'h48, r);
		int_enable = 1'b1;
		// transmit in both frame modes with a random ninth bit
		for (i = 0; i < 4; i++)
		begin
			m = i[0];
			b = 1'($urandom);
			wr(SCON_ADDR, ctl(m, 0, 0, b, 0, 0, 0));
			tx_data = 8'($urandom);
			c0 = cap_cnt;
			tx_start = 1'b1;
			@(negedge ref_clk);
			tx_start = 1'b0;
			for (n = 0; n < 200 && cap_cnt == c0; n++)
				@(negedge ref_clk);
			tmo(cap_cnt != c0);
			chk("tx_frame", {1'b1, m ? b : 1'b1, tx_data}, cap);
			for (n = 0; n < 100 && tx_busy !== 1'b0; n++)
				@(negedge ref_clk);
			tmo(tx_busy === 1'b0);
			repeat (20) @(negedge ref_clk);
			rd(r);
			chk("ctrl_tx", ctl(m, 0, 0, b, 0, 1, 0), r);
			chk("int_tx", 1'b1, int_req);
			wr(SCON_ADDR, ctl(m, 0, 0, b, 0, 0, 0));
			@(negedge ref_clk);
			chk("int_clr", 1'b0, int_req);
		end
		// every mode, filter and level, last case with receiver off
		for (i = 0; i < 9; i++)
		begin
			{b, mce, m} = 3'(i);
			ren = (i < 8);
			c.data = 8'($urandom);
			c.ninth = b;
			seen = 1'b0;
			a = ren & (~mce | b);
			wr(SCON_ADDR, ctl(m, mce, ren, 0, 0, 0, 0));
			fork
				u_usc_remote.send(c, m, m | b, 1 + $urandom_range(5));
				for (k = 0; k < 80 && !seen; k++)
				begin
					@(negedge ref_clk);
					seen = (rx_valid === 1'b1);
					got = rx_data;
				end
			join
			chk("rx_seen", a, seen);
			if (a)
				chk("rx_data", c.data, got);
			rd(r);
			chk("ctrl_ri", a, r[BIT_RI]);
			if (a)
				chk("ctrl_rx", ctl(m, mce, ren, 0, b, 0, 1), r);
			chk("int_rx", a, int_req);
		end
		// stalled sink: two characters kept, the third lost
		wr(SCON_ADDR, ctl(0, 0, 1, 0, 0, 0, 0));
		rx_ready = 1'b0;
		for (i = 0; i < 3; i++)
			u_usc_remote.send({1'b0, 8'(8'hA0 + i)}, 0, 1, 1);
		repeat (10) @(negedge ref_clk);
		rx_ready = 1'b1;
		n = 0;
		for (k = 0; k < 20; k++)
		begin
			@(negedge ref_clk);
			if (rx_valid === 1'b1 && n++ == 0)
				got = rx_data;
		end
		chk("buf_cnt", 10'h002, 10'(n));
		chk("buf_first", 8'hA0, got);
		// flag stays until software clears it; masking drops the request
		rd(r);
		chk("ctrl_ri_kept", 1'b1, r[BIT_RI]);
		chk("int_rx_held", 1'b1, int_req);
		int_enable = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("int_masked", 1'b0, int_req);
		end_of_test;
	end
endmodule
`default_nettype wire
